// file: src/wfpm_map.vh
/*
  Register map, field positions, reset values and CRC constants of the
  wake-up frame pattern matcher.
  Assumes it is included by its bare name from the design files only.
*/
`ifndef WFPM_MAP_VH
`define WFPM_MAP_VH

// ------------------------------------------------------------
// Banks
// ------------------------------------------------------------
`define WFPM_BANK_CTRL 4'h3
`define WFPM_BANK_SLOT0 4'h4
`define WFPM_BANK_SLOT1 4'h5
`define WFPM_BANK_SLOT2 4'h6

// ------------------------------------------------------------
// Offsets inside a bank
// ------------------------------------------------------------
`define WFPM_OFS_CRC_LO 4'h0
`define WFPM_OFS_CRC_HI 4'h2
`define WFPM_OFS_MASK0 4'h4
`define WFPM_OFS_MASK3 4'ha
`define WFPM_OFS_STAT 4'h4
`define WFPM_OFS_IMSK 4'h6
`define WFPM_OFS_WCTL 4'ha
`define WFPM_OFS_BSEL 4'he

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define WFPM_RST_REG 16'h0000
`define WFPM_RST_BITS 4'h0
`define WFPM_EN_SLOT1 1
`define WFPM_MASK_WORDS 4
`define WFPM_PAT_BYTES 7'h40

// ------------------------------------------------------------
// IEEE 802.3 CRC-32, reflected form
// ------------------------------------------------------------
`define WFPM_CRC_POLY 32'hedb88320
`define WFPM_CRC_INIT 32'hffffffff

`endif

// file: src/wfpm_top.v
/*
  Wake-up frame pattern matcher: banked 16-bit register file for pattern
  slots 1 and 2 (plus the last mask word of slot 0), a per-slot masked
  CRC-32 over the first 64 bytes of each received frame, and a sticky
  match status with a maskable interrupt.
  Assumes a receive path that presents one byte per cycle with rx_valid,
  flags the final byte with rx_last, and is synchronous to clk_sys.
*/
`include "wfpm_map.vh"

module wfpm_top #(
  parameter N_SLOT = 2
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  // Receive byte stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  // Results
  output reg [N_SLOT-1:0] wake_match_q,
  output reg irq_q
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [3:0] bsel_q;
  reg [3:0] wctl_q;
  reg [3:0] imsk_q;
  reg [3:0] stat_q;
  reg [3:0] stat_d;
  reg [15:0] s0_msk3_q;
  reg [15:0] crc_lo_q [0:N_SLOT-1];
  reg [15:0] crc_hi_q [0:N_SLOT-1];
  reg [15:0] msk_q [0:N_SLOT*`WFPM_MASK_WORDS-1];
  reg [15:0] rd_d;
  reg [6:0] pos_q;
  wire [N_SLOT-1:0] hit;
  integer i;
  integer k;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Banked decode; the bank select itself is visible in every bank
  function sel;
    input [3:0] bank;
    input [3:0] ofs;
    begin
      sel = (bsel_q == bank) && (reg_addr == ofs);
    end
  endfunction

  // One byte of reflected CRC-32, least significant bit first
  function [31:0] crc_upd;
    input [31:0] c;
    input [7:0] d;
    integer b;
    reg [31:0] x;
    begin
      x = c;
      for (b = 0; b < 8; b = b + 1) begin
        if (x[0] ^ d[b])
          x = (x >> 1) ^ `WFPM_CRC_POLY;
        else
          x = x >> 1;
      end
      crc_upd = x;
    end
  endfunction

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------

  // All writable registers; a write to an unmapped offset is dropped
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bsel_q <= `WFPM_RST_BITS;
      wctl_q <= `WFPM_RST_BITS;
      imsk_q <= `WFPM_RST_BITS;
      s0_msk3_q <= `WFPM_RST_REG;
      for (i = 0; i < N_SLOT; i = i + 1) begin
        crc_lo_q[i] <= `WFPM_RST_REG;
        crc_hi_q[i] <= `WFPM_RST_REG;
      end
      for (i = 0; i < N_SLOT * `WFPM_MASK_WORDS; i = i + 1) begin
        msk_q[i] <= `WFPM_RST_REG;
      end
    end else if (ce && reg_wr) begin
      if (reg_addr == `WFPM_OFS_BSEL)
        bsel_q <= reg_wdata[3:0];
      if (sel(`WFPM_BANK_CTRL, `WFPM_OFS_WCTL))
        wctl_q <= reg_wdata[3:0];
      if (sel(`WFPM_BANK_CTRL, `WFPM_OFS_IMSK))
        imsk_q <= reg_wdata[3:0];
      if (sel(`WFPM_BANK_SLOT0, `WFPM_OFS_MASK3))
        s0_msk3_q <= reg_wdata;
      for (i = 0; i < N_SLOT; i = i + 1) begin
        // Slot banks follow one another from slot 1 upward
        if (sel(`WFPM_BANK_SLOT1 + i[3:0], `WFPM_OFS_CRC_LO))
          crc_lo_q[i] <= reg_wdata;
        if (sel(`WFPM_BANK_SLOT1 + i[3:0], `WFPM_OFS_CRC_HI))
          crc_hi_q[i] <= reg_wdata;
        for (k = 0; k < `WFPM_MASK_WORDS; k = k + 1) begin
          if (sel(`WFPM_BANK_SLOT1 + i[3:0],
                  `WFPM_OFS_MASK0 + {k[2:0], 1'b0}))
            msk_q[i * `WFPM_MASK_WORDS + k] <= reg_wdata;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------

  // Read mux; unmapped offsets and reserved bits read as zero
  always @* begin
    rd_d = `WFPM_RST_REG;
    if (reg_addr == `WFPM_OFS_BSEL)
      rd_d = {12'h000, bsel_q};
    if (sel(`WFPM_BANK_CTRL, `WFPM_OFS_WCTL))
      rd_d = {12'h000, wctl_q};
    if (sel(`WFPM_BANK_CTRL, `WFPM_OFS_IMSK))
      rd_d = {12'h000, imsk_q};
    if (sel(`WFPM_BANK_CTRL, `WFPM_OFS_STAT))
      rd_d = {12'h000, stat_q};
    if (sel(`WFPM_BANK_SLOT0, `WFPM_OFS_MASK3))
      rd_d = s0_msk3_q;
    for (i = 0; i < N_SLOT; i = i + 1) begin
      if (sel(`WFPM_BANK_SLOT1 + i[3:0], `WFPM_OFS_CRC_LO))
        rd_d = crc_lo_q[i];
      if (sel(`WFPM_BANK_SLOT1 + i[3:0], `WFPM_OFS_CRC_HI))
        rd_d = crc_hi_q[i];
      for (k = 0; k < `WFPM_MASK_WORDS; k = k + 1) begin
        if (sel(`WFPM_BANK_SLOT1 + i[3:0],
                `WFPM_OFS_MASK0 + {k[2:0], 1'b0}))
          rd_d = msk_q[i * `WFPM_MASK_WORDS + k];
      end
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      reg_rdata_q <= `WFPM_RST_REG;
    else if (ce)
      reg_rdata_q <= reg_rd ? rd_d : `WFPM_RST_REG;
  end

  // ------------------------------------------------------------
  // Frame byte position
  // ------------------------------------------------------------

  // Saturates at 64 so bytes past the pattern window never count
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      pos_q <= 7'h00;
    else if (ce && rx_valid) begin
      if (rx_last)
        pos_q <= 7'h00;
      else if (pos_q != `WFPM_PAT_BYTES)
        pos_q <= pos_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Per-slot masked CRC
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_SLOT; g = g + 1) begin : g_slot
      reg [31:0] crc_q;
      wire [15:0] mword;
      wire take;
      wire [31:0] crc_nx;
      wire en;
      // Mask word by byte position bits 5:4, bit by bits 3:0
      assign mword = msk_q[g * `WFPM_MASK_WORDS + pos_q[5:4]];
      // Words 1 to 3 cover bytes 17-32, 33-48 and 49-64 in turn
      assign take = rx_valid && (pos_q < `WFPM_PAT_BYTES) &&
                    mword[pos_q[3:0]];
      assign crc_nx = take ? crc_upd(crc_q, rx_data) : crc_q;
      assign en = wctl_q[g + `WFPM_EN_SLOT1];
      // Compare including the final byte; short frames just end early
      assign hit[g] = ce && rx_valid && rx_last && en &&
        (~crc_nx == {crc_hi_q[g], crc_lo_q[g]});

      // Running CRC restarts after every frame end
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          crc_q <= `WFPM_CRC_INIT;
        else if (ce && rx_valid)
          crc_q <= rx_last ? `WFPM_CRC_INIT : crc_nx;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Status, interrupt and match pulses
  // ------------------------------------------------------------

  // Read of status clears it, but a match in the same cycle survives
  always @* begin
    stat_d = stat_q;
    if (reg_rd && sel(`WFPM_BANK_CTRL, `WFPM_OFS_STAT))
      stat_d = `WFPM_RST_BITS;
    for (i = 0; i < N_SLOT; i = i + 1) begin
      if (hit[i])
        stat_d[i + `WFPM_EN_SLOT1] = 1'b1;
    end
  end

  // Interrupt follows the next status so both change on one edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= `WFPM_RST_BITS;
      irq_q <= 1'b0;
      wake_match_q <= {N_SLOT{1'b0}};
    end else if (ce) begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & imsk_q);
      wake_match_q <= hit;
    end
  end

endmodule

// file: sim/wfpm_asserts.sv
/* Port checker for wfpm_top.
   Assumes one clock domain and a bind onto every wfpm_top. */
module wfpm_asserts #(
  parameter N_SLOT = 2
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  // Receive stream and results
  input wire rx_valid,
  input wire rx_last,
  input wire [N_SLOT-1:0] wake_match_q,
  input wire irq_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // Frame steps
  // ----
  sequence mid_s;
    ce && rx_valid && !rx_last;
  endsequence
  // A pulse with no frame end beside it must not repeat
  sequence pulse_s;
    wake_match_q != 0 && !(ce && rx_valid && rx_last);
  endsequence
  rst_out_a: assert property ($rose(rst_n) |-> reg_rdata_q == 0 &&
    wake_match_q == 0 && !irq_q) else $error("outputs not clear");
  rd_idle_a: assert property (ce && !reg_rd |=> reg_rdata_q == 0)
    else $error("read data outside read slot");
  match_cause_a: assert property (wake_match_q != 0 |->
    $past(ce && rx_valid && rx_last)) else $error("match without end");
  match_mid_a: assert property (mid_s |=> wake_match_q == 0)
    else $error("match inside frame");
  match_once_a: assert property (pulse_s |=> wake_match_q == 0)
    else $error("match pulse too long");
  irq_rise_a: assert property ($rose(irq_q) |->
    wake_match_q != 0 || $past(reg_wr)) else $error("irq without cause");
  irq_fall_a: assert property ($fell(irq_q) |->
    $past(reg_rd || reg_wr)) else $error("irq dropped unasked");
  irq_hold_a: assert property (irq_q && !reg_rd && !reg_wr |=>
    irq_q) else $error("irq not held");
endmodule

bind wfpm_top wfpm_asserts #(.N_SLOT(N_SLOT)) i_wfpm_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .rx_valid(rx_valid),
  .rx_last(rx_last), .wake_match_q(wake_match_q), .irq_q(irq_q));

// file: sim/wfpm_rx_model.sv
/* Receive path model: plays one frame from frm, byte by byte.
   Assumes the bench fills frm before calling send. */
module wfpm_rx_model (
  // Clock
  input wire clk_sys,
  // Byte stream towards the matcher
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] frm [0:79];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // Idle after every fifth byte so gapped streams get exercised;
  // idle data is inverted so a stale byte never looks valid
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= frm[i];
      rx_last <= (i == n - 1);
      if (i % 5 == 4 && i != n - 1) begin
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_data <= ~frm[i];
      end
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~frm[n - 1];
  endtask
endmodule

// file: sim/test_wakeup_frame_pattern_match.sv
/* Self-checking bench for wfpm_top.
   Assumes wfpm_asserts is bound and wfpm_rx_model plays frames. */
module test_wakeup_frame_pattern_match;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [63:0] mask;
    logic [6:0] len;
    logic [3:0] ctl;
    logic [1:0] bad;
    logic [1:0] exp;
  } wfpm_row_t;
  // Mask edges of each word, disabled slots, long and short frames
  wfpm_row_t rows [0:5] = '{
    '{64'h8001, 7'h3c, 4'h6, 2'h0, 2'h3},
    '{64'h80010000, 7'h40, 4'h6, 2'h2, 2'h1},
    '{64'h800100000000, 7'h40, 4'h2, 2'h0, 2'h1},
    '{64'h8001000000000000, 7'h46, 4'h4, 2'h0, 2'h2},
    '{64'hffffffffffffffff, 7'h28, 4'h6, 2'h1, 2'h2},
    '{64'hffffffffffffffff, 7'h28, 4'h9, 2'h0, 2'h0}};
  logic clk_sys, rst_n, ce, reg_wr, reg_rd, irq_q;
  logic rx_valid, rx_last;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q;
  logic [7:0] rx_data;
  logic [1:0] wake_match_q;
  logic [31:0] c;
  int n_mismatch = 0, samples_checked = 0;
  wfpm_top #(.N_SLOT(2)) i_wfpm_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .wake_match_q(wake_match_q),
    .irq_q(irq_q));
  wfpm_rx_model i_wfpm_rx_model (.clk_sys(clk_sys), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] pat_crc(logic [63:0] m, int n);
    logic [31:0] x;
    x = 32'hffffffff;
    for (int i = 0; i < 64 && i < n; i++) if (m[i]) begin
      x ^= {24'h000000, i_wfpm_rx_model.frm[i]};
      for (int b = 0; b < 8; b++) x = x[0] ? (x >> 1) ^ 32'hedb88320 : x >> 1;
    end
    return ~x;
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e);
  endtask
  // Bank first: offsets repeat in every bank
  task automatic prog(logic [3:0] bk, logic [31:0] x, logic [63:0] m);
    wr(4'he, {12'h000, bk});
    wr(4'h0, x[15:0]);
    wr(4'h2, x[31:16]);
    for (int k = 0; k < 4; k++) wr(4'(2 * k + 4), m[16 * k +: 16]);
  endtask
  task automatic give_verdict;
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Hang guard, well beyond the roughly 700 cycles the run needs
  initial begin
    #400us;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    ce = 1'b1;
    for (int i = 0; i < 80; i++) i_wfpm_rx_model.frm[i] = 8'(i * 37 + 5);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int b = 5; b < 7; b++) begin
      wr(4'he, 16'(b));
      for (int k = 0; k < 7; k++) rd(4'(2 * k), 16'h0000);
    end
    wr(4'h0, 16'h5678);
    wr(4'h2, 16'habcd);
    wr(4'hc, 16'hffff);
    wr(4'he, 16'h0005);
    wr(4'h0, 16'h1234);
    rd(4'h0, 16'h1234);
    wr(4'he, 16'h0006);
    rd(4'h0, 16'h5678);
    rd(4'h2, 16'habcd);
    rd(4'hc, 16'h0000);
    wr(4'he, 16'h0003);
    wr(4'h6, 16'h0002);
    foreach (rows[r]) begin
      c = pat_crc(rows[r].mask, rows[r].len);
      prog(4'h5, c ^ {30'h0, rows[r].bad[0]}, rows[r].mask);
      prog(4'h6, c ^ {30'h0, rows[r].bad[1]}, rows[r].mask);
      wr(4'he, 16'h0003);
      wr(4'ha, {12'h000, rows[r].ctl});
      i_wfpm_rx_model.send(rows[r].len);
      #1 chk({14'h0, wake_match_q}, {14'h0, rows[r].exp});
      chk({15'h0, irq_q}, {15'h0, rows[r].exp[0]});
      rd(4'h4, {13'h0, rows[r].exp, 1'b0});
      chk({15'h0, irq_q}, 16'h0000);
    end
    give_verdict;
  end
endmodule
